// File: rtl/dtl_pkg.sv
package dtl_pkg;

	// ----------------------------------------
	// Register addresses (read side)
	// ----------------------------------------
	localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] RD_REMOTE_INT = 8'h01;
	localparam logic [7:0] RD_FLAGS = 8'h02;
	localparam logic [7:0] RD_SETUP = 8'h03;
	localparam logic [7:0] RD_RATE = 8'h04;
	localparam logic [7:0] RD_LOCAL_HI = 8'h05;
	localparam logic [7:0] RD_LOCAL_LO = 8'h06;
	localparam logic [7:0] RD_REMOTE_HI = 8'h07;
	localparam logic [7:0] RD_REMOTE_LO = 8'h08;
	localparam logic [7:0] RD_REMOTE_FRAC = 8'h10;
	localparam logic [7:0] RD_MAKER = 8'hfe;
	localparam logic [7:0] RD_REVISION = 8'hff;

	// ----------------------------------------
	// Register addresses (write side)
	// ----------------------------------------
	localparam logic [7:0] WR_SETUP = 8'h09;
	localparam logic [7:0] WR_RATE = 8'h0a;
	localparam logic [7:0] WR_LOCAL_HI = 8'h0b;
	localparam logic [7:0] WR_LOCAL_LO = 8'h0c;
	localparam logic [7:0] WR_REMOTE_HI = 8'h0d;
	localparam logic [7:0] WR_REMOTE_LO = 8'h0e;
	localparam logic [7:0] WR_ONE_SHOT = 8'h0f;

	// ----------------------------------------
	// Same address for read and write
	// ----------------------------------------
	localparam logic [7:0] RW_OFFSET_INT = 8'h11;
	localparam logic [7:0] RW_OFFSET_FRAC = 8'h12;
	localparam logic [7:0] RW_REMOTE_HI_FRAC = 8'h13;
	localparam logic [7:0] RW_REMOTE_LO_FRAC = 8'h14;
	localparam logic [7:0] RW_REMOTE_SHUT = 8'h19;
	localparam logic [7:0] RW_LOCAL_SHUT = 8'h20;
	localparam logic [7:0] RW_SHUT_HYST = 8'h21;
	localparam logic [7:0] RW_REPEAT = 8'h22;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h08;
	localparam logic [7:0] RST_UPPER = 8'h55;
	localparam logic [7:0] RST_SHUT = 8'h55;
	localparam logic [7:0] RST_HYST = 8'h0a;
	localparam logic [7:0] RST_REPEAT = 8'h01;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SETUP_EXT_RANGE = 2;
	localparam int SETUP_PIN6_SHUT = 5;
	localparam int SETUP_STANDBY = 6;
	localparam int SETUP_ALARM_MASK = 7;
	localparam int REPEAT_TIMEOUT_EN = 7;
	localparam int FLAG_LOCAL_SHUT = 0;
	localparam int FLAG_REMOTE_SHUT = 1;
	localparam int FLAG_OPEN = 2;
	localparam int FLAG_REMOTE_LO = 3;
	localparam int FLAG_REMOTE_HI = 4;
	localparam int FLAG_LOCAL_LO = 5;
	localparam int FLAG_LOCAL_HI = 6;
	localparam logic [7:0] ALARM_FLAGS = 8'h7c;

	// ----------------------------------------
	// Conversion and timing
	// ----------------------------------------
	localparam logic [7:0] RATE_NO_AVG = 8'h07;
	localparam logic [3:0] AVG_LAST = 4'hf;
	localparam logic signed [13:0] EXT_BIAS = 14'sh0100;
	localparam logic signed [13:0] NORMAL_TOP = 14'sh01ff;
	localparam logic signed [13:0] EXT_TOP = 14'sh03ff;
	localparam logic [9:0] NORMAL_CLAMP = 10'h1fc;
	localparam logic [9:0] EXT_CLAMP = 10'h3ff;
	localparam int CLK_HZ = 125_000_000;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

	typedef enum logic [1:0] {EV_FIRST, EV_NEXT, EV_READ} dtl_ev_t;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_STORE} dtl_conv_state_t;

endpackage

// File: rtl/dtl_xfer_if.sv
`timescale 1ns/100ps
interface dtl_xfer_if;
	import dtl_pkg::*;
	logic ev_toggle;
	dtl_ev_t ev_kind;
	logic [7:0] ev_byte;
	logic rsp_toggle;
	logic [7:0] rsp_byte;
	modport link (output ev_toggle, output ev_kind, output ev_byte,
		input rsp_toggle, input rsp_byte);
	modport core (input ev_toggle, input ev_kind, input ev_byte,
		output rsp_toggle, output rsp_byte);
endinterface

// File: rtl/dtl_link.sv
`timescale 1ns/100ps
module dtl_link import dtl_pkg::*; (
	// Clock and reset
	input wire logic link_clk,
	input wire logic rst,
	// Link party
	input wire logic link_frame,
	input wire logic link_byte_valid,
	input wire logic [7:0] link_byte,
	input wire logic link_read_req,
	output logic [7:0] link_read_data,
	output logic link_read_valid,
	output logic link_busy,
	// Toward the register core
	dtl_xfer_if.link xfer
);

	logic rst_s1, rst_s2, lrst;
	logic first_byte, pending, pending_read;
	logic rsp_s1, rsp_s2, rsp_s3;
	wire accept = !pending && (link_byte_valid || link_read_req);
	wire acked = rsp_s2 ^ rsp_s3;

	// ----------------------------------------
	// Reset and answer crossing
	// ----------------------------------------
	always_ff @(posedge link_clk) begin
		rst_s1 <= rst;
		rst_s2 <= rst_s1;
		lrst <= rst_s2;
	end

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			rsp_s1 <= 1'b0;
			rsp_s2 <= 1'b0;
			rsp_s3 <= 1'b0;
		end else begin
			rsp_s1 <= xfer.rsp_toggle;
			rsp_s2 <= rsp_s1;
			rsp_s3 <= rsp_s2;
		end
	end

	// ----------------------------------------
	// One event in flight at a time
	// ----------------------------------------
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			first_byte <= 1'b1;
			pending <= 1'b0;
			pending_read <= 1'b0;
			xfer.ev_toggle <= 1'b0;
			xfer.ev_kind <= EV_FIRST;
			xfer.ev_byte <= RST_ZERO;
			link_read_data <= RST_ZERO;
			link_read_valid <= 1'b0;
		end else begin
			link_read_valid <= acked && pending_read;
			if (acked) begin
				pending <= 1'b0;
				pending_read <= 1'b0;
				if (pending_read)
					link_read_data <= xfer.rsp_byte;
			end
			// Byte order is carried by the frame itself
			if (!link_frame)
				first_byte <= 1'b1;
			if (accept) begin
				pending <= 1'b1;
				pending_read <= !link_byte_valid;
				xfer.ev_toggle <= ~xfer.ev_toggle;
				xfer.ev_byte <= link_byte;
				if (link_byte_valid) begin
					xfer.ev_kind <= first_byte ? EV_FIRST : EV_NEXT; // see (R18)
					first_byte <= 1'b0;
				end else begin
					xfer.ev_kind <= EV_READ;
				end
			end
		end
	end

	assign link_busy = pending;

endmodule // dtl_link

// File: rtl/dtl_bank.sv
`timescale 1ns/100ps
// How it works
// (R1) Convert continuously, alternating local and remote
// (R2) Compare each result, record out-of-limit flags
// (R3) Alarm pin low on high or low violation
// (R4) Alarm pin also low on open diode
// (R5) Shutdown pin low above shutdown limit
// (R6) Average sixteen samples only at slow rates
// (R7) Local result byte at 0x00, 1 degree
// (R8) Remote integer 0x01, quarter fraction 0x10
// (R9) Fraction read freezes integer until read
// (R10) Setup bit 2 selects extended range
// (R11) Extended range adds sixty-four degrees
// (R12) New range valid from next measurement
// (R13) Write to 0x0F triggers one measurement
// (R14) Separate read and write addresses decoded
// (R15) Offset and limit fractions same address
// (R16) Shutdown limits and hysteresis, hysteresis ten
// (R17) Shutdown releases at limit minus hysteresis
// (R18) First write byte loads the pointer
// (R19) Repeat register bit 7 enables timeout
// (R20) Normal range clamps at 0 and 127
// (R21) Read-only registers ignore writes
module dtl_bank import dtl_pkg::*; #(
	parameter int TIMEOUT_LEN = TIMEOUT_CYCLES,
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Register link
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic link_byte_valid,
	input wire logic [7:0] link_byte,
	input wire logic link_read_req,
	output logic [7:0] link_read_data,
	output logic link_read_valid,
	output logic link_busy,
	// Converter
	output logic conv_start,
	output logic conv_remote,
	input wire logic sample_valid,
	input wire logic signed [11:0] sample_temp,
	input wire logic diode_open,
	// Open-drain pins
	input wire logic overtemp_shutdown_n_in,
	output logic overtemp_shutdown_n_out,
	output logic overtemp_shutdown_n_oe_n,
	input wire logic alarm_or_second_shutdown_n_in,
	output logic alarm_or_second_shutdown_n_out,
	output logic alarm_or_second_shutdown_n_oe_n
);

	localparam int TW = $clog2(TIMEOUT_LEN + 1);

	dtl_xfer_if xfer ();

	dtl_link u_link (
		.link_clk(link_clk),
		.rst(rst),
		.link_frame(link_frame),
		.link_byte_valid(link_byte_valid),
		.link_byte(link_byte),
		.link_read_req(link_read_req),
		.link_read_data(link_read_data),
		.link_read_valid(link_read_valid),
		.link_busy(link_busy),
		.xfer(xfer.link)
	);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] local_temp_value, remote_temp_value_int, remote_temp_value_frac;
	logic [7:0] limit_flags, device_setup, sample_rate_select;
	logic [7:0] local_upper_limit, local_lower_limit;
	logic [7:0] remote_upper_limit_int, remote_lower_limit_int;
	logic [7:0] remote_offset_int, remote_offset_frac;
	logic [7:0] remote_upper_limit_frac, remote_lower_limit_frac;
	logic [7:0] remote_shutdown_limit, local_shutdown_limit;
	logic [7:0] shutdown_hysteresis, alarm_repeat_count, register_pointer, rd_mux;

	// ----------------------------------------
	// Link crossing and byte sequencing
	// ----------------------------------------
	logic ev_s1, ev_s2, ev_s3, data_expected, frac_lock;
	logic open_s1, open_s2;
	logic [TW-1:0] idle_cnt;

	wire ev_seen = ev_s2 ^ ev_s3;
	wire ev_first = ev_seen && xfer.ev_kind == EV_FIRST;
	wire ev_read = ev_seen && xfer.ev_kind == EV_READ;
	wire wr_hit = ev_seen && xfer.ev_kind == EV_NEXT && data_expected;
	wire [7:0] wr_data = xfer.ev_byte;
	wire timeout_en = alarm_repeat_count[REPEAT_TIMEOUT_EN];
	wire timed_out = timeout_en && idle_cnt == TW'(TIMEOUT_LEN);

	always_ff @(posedge clock) begin
		if (rst) begin
			ev_s1 <= 1'b0;
			ev_s2 <= 1'b0;
			ev_s3 <= 1'b0;
			open_s1 <= 1'b0;
			open_s2 <= 1'b0;
		end else if (ce) begin
			ev_s1 <= xfer.ev_toggle;
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
			open_s1 <= diode_open;
			open_s2 <= open_s1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			register_pointer <= RST_ZERO;
			data_expected <= 1'b0;
			idle_cnt <= '0;
			xfer.rsp_toggle <= 1'b0;
			xfer.rsp_byte <= RST_ZERO;
		end else if (ce) begin
			if (ev_seen) begin
				xfer.rsp_toggle <= ~xfer.rsp_toggle;
				idle_cnt <= '0;
			end else if (!data_expected || timed_out) begin
				idle_cnt <= '0;
			end else begin
				idle_cnt <= idle_cnt + 1'b1;
			end
			if (ev_first) begin
				register_pointer <= wr_data; // see (R18)
				data_expected <= 1'b1;
			end else if (wr_hit || timed_out) begin
				data_expected <= 1'b0; // see (R19)
			end
			if (ev_read)
				xfer.rsp_byte <= rd_mux; // see (R18)
		end
	end

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Read-only addresses have no entry here, so their data is dropped
	wire wr_setup = wr_hit && register_pointer == WR_SETUP; // see (R14)
	wire wr_rate = wr_hit && register_pointer == WR_RATE;
	wire wr_local_hi = wr_hit && register_pointer == WR_LOCAL_HI;
	wire wr_local_lo = wr_hit && register_pointer == WR_LOCAL_LO;
	wire wr_remote_hi = wr_hit && register_pointer == WR_REMOTE_HI;
	wire wr_remote_lo = wr_hit && register_pointer == WR_REMOTE_LO;
	wire wr_one_shot = wr_hit && register_pointer == WR_ONE_SHOT; // see (R13)
	wire wr_off_int = wr_hit && register_pointer == RW_OFFSET_INT; // see (R15)
	wire wr_off_frac = wr_hit && register_pointer == RW_OFFSET_FRAC;
	wire wr_hi_frac = wr_hit && register_pointer == RW_REMOTE_HI_FRAC;
	wire wr_lo_frac = wr_hit && register_pointer == RW_REMOTE_LO_FRAC;
	wire wr_remote_shut = wr_hit && register_pointer == RW_REMOTE_SHUT; // see (R16)
	wire wr_local_shut = wr_hit && register_pointer == RW_LOCAL_SHUT;
	wire wr_hyst = wr_hit && register_pointer == RW_SHUT_HYST;
	wire wr_repeat = wr_hit && register_pointer == RW_REPEAT;

	always_ff @(posedge clock) begin
		if (rst) begin
			device_setup <= RST_ZERO;
			sample_rate_select <= RST_RATE;
			local_upper_limit <= RST_UPPER;
			local_lower_limit <= RST_ZERO;
			remote_upper_limit_int <= RST_UPPER;
			remote_lower_limit_int <= RST_ZERO;
			remote_offset_int <= RST_ZERO;
			remote_offset_frac <= RST_ZERO;
			remote_upper_limit_frac <= RST_ZERO;
			remote_lower_limit_frac <= RST_ZERO;
			remote_shutdown_limit <= RST_SHUT;
			local_shutdown_limit <= RST_SHUT;
			shutdown_hysteresis <= RST_HYST; // see (R16)
			alarm_repeat_count <= RST_REPEAT; // see (R19)
		end else if (ce) begin
			if (wr_setup) device_setup <= wr_data;
			if (wr_rate) sample_rate_select <= wr_data;
			if (wr_local_hi) local_upper_limit <= wr_data;
			if (wr_local_lo) local_lower_limit <= wr_data;
			if (wr_remote_hi) remote_upper_limit_int <= wr_data;
			if (wr_remote_lo) remote_lower_limit_int <= wr_data;
			if (wr_off_int) remote_offset_int <= wr_data;
			if (wr_off_frac) remote_offset_frac <= wr_data;
			if (wr_hi_frac) remote_upper_limit_frac <= wr_data;
			if (wr_lo_frac) remote_lower_limit_frac <= wr_data;
			if (wr_remote_shut) remote_shutdown_limit <= wr_data;
			if (wr_local_shut) local_shutdown_limit <= wr_data;
			if (wr_hyst) shutdown_hysteresis <= wr_data;
			if (wr_repeat) alarm_repeat_count <= wr_data;
		end
	end

	// ----------------------------------------
	// Read select
	// ----------------------------------------
	always_comb begin
		case (register_pointer)
			RD_LOCAL_TEMP: rd_mux = local_temp_value; // see (R7)
			RD_REMOTE_INT: rd_mux = remote_temp_value_int; // see (R8)
			RD_FLAGS: rd_mux = limit_flags;
			RD_SETUP: rd_mux = device_setup; // see (R14)
			RD_RATE: rd_mux = sample_rate_select;
			RD_LOCAL_HI: rd_mux = local_upper_limit;
			RD_LOCAL_LO: rd_mux = local_lower_limit;
			RD_REMOTE_HI: rd_mux = remote_upper_limit_int;
			RD_REMOTE_LO: rd_mux = remote_lower_limit_int;
			RD_REMOTE_FRAC: rd_mux = remote_temp_value_frac; // see (R8)
			RW_OFFSET_INT: rd_mux = remote_offset_int; // see (R15)
			RW_OFFSET_FRAC: rd_mux = remote_offset_frac;
			RW_REMOTE_HI_FRAC: rd_mux = remote_upper_limit_frac;
			RW_REMOTE_LO_FRAC: rd_mux = remote_lower_limit_frac;
			RW_REMOTE_SHUT: rd_mux = remote_shutdown_limit; // see (R16)
			RW_LOCAL_SHUT: rd_mux = local_shutdown_limit;
			RW_SHUT_HYST: rd_mux = shutdown_hysteresis;
			RW_REPEAT: rd_mux = alarm_repeat_count;
			RD_MAKER: rd_mux = MAKER_CODE;
			RD_REVISION: rd_mux = REVISION;
			default: rd_mux = RST_ZERO;
		endcase
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	dtl_conv_state_t state, next_state;
	logic signed [15:0] acc;
	logic signed [11:0] meas;
	logic [3:0] avg_cnt;
	logic [1:0] shots_left;

	wire standby = device_setup[SETUP_STANDBY];
	wire avg_on = sample_rate_select < RATE_NO_AVG; // see (R6)
	wire signed [15:0] acc_sum = acc + 16'(sample_temp);
	wire avg_done = !avg_on || avg_cnt == AVG_LAST;
	wire signed [11:0] avg_value = avg_on ? acc_sum[15:4] : sample_temp;

	always_comb begin
		case (state)
			ST_IDLE: next_state = (!standby || shots_left != 2'd0) ? ST_START : ST_IDLE; // see (R1)
			ST_START: next_state = ST_WAIT;
			ST_WAIT: next_state = !sample_valid ? ST_WAIT : (avg_done ? ST_STORE : ST_START);
			ST_STORE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	assign conv_start = state == ST_START;

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ST_IDLE;
			acc <= '0;
			avg_cnt <= '0;
			meas <= '0;
			conv_remote <= 1'b0;
			shots_left <= 2'd0;
		end else if (ce) begin
			state <= next_state;
			if (state == ST_WAIT && sample_valid) begin
				acc <= avg_done ? '0 : acc_sum;
				avg_cnt <= avg_done ? '0 : avg_cnt + 1'b1;
				if (avg_done)
					meas <= avg_value;
			end
			if (state == ST_STORE)
				conv_remote <= ~conv_remote; // see (R1)
			// One shot measures both channels once
			if (wr_one_shot)
				shots_left <= 2'd2; // see (R13)
			else if (state == ST_STORE && shots_left != 2'd0)
				shots_left <= shots_left - 1'b1;
		end
	end

	// ----------------------------------------
	// Result encoding and comparison
	// ----------------------------------------
	wire ext_range = device_setup[SETUP_EXT_RANGE]; // see (R10)
	wire signed [13:0] offset_q = 14'(signed'({remote_offset_int, remote_offset_frac[7:6]}));
	wire signed [13:0] adjusted = 14'(meas) + (conv_remote ? offset_q : 14'sh0000);
	wire signed [13:0] biased = ext_range ? adjusted + EXT_BIAS : adjusted; // see (R11)
	wire signed [13:0] top = ext_range ? EXT_TOP : NORMAL_TOP;
	// Range is read at store time, so the next result uses the new format
	wire [9:0] code = biased < 14'sh0000 ? 10'h000 : // see (R20) (R12)
		(biased > top ? (ext_range ? EXT_CLAMP : NORMAL_CLAMP) : biased[9:0]);
	wire [7:0] code_int = code[9:2];

	wire store = ce && state == ST_STORE;
	wire store_local = store && !conv_remote;
	wire store_remote = store && conv_remote;
	wire local_hi = code_int > local_upper_limit;
	wire local_lo = code_int < local_lower_limit;
	wire remote_hi = code > {remote_upper_limit_int, remote_upper_limit_frac[7:6]};
	wire remote_lo = code < {remote_lower_limit_int, remote_lower_limit_frac[7:6]};
	wire [8:0] code_plus_hyst = {1'b0, code_int} + {1'b0, shutdown_hysteresis};
	wire local_over = code_int > local_shutdown_limit;
	wire remote_over = code_int > remote_shutdown_limit;
	wire local_rel = code_plus_hyst <= {1'b0, local_shutdown_limit};
	wire remote_rel = code_plus_hyst <= {1'b0, remote_shutdown_limit};

	always_ff @(posedge clock) begin
		if (rst) begin
			local_temp_value <= RST_ZERO;
			remote_temp_value_int <= RST_ZERO;
			remote_temp_value_frac <= RST_ZERO;
			frac_lock <= 1'b0;
		end else if (ce) begin
			if (store_local)
				local_temp_value <= code_int; // see (R1) (R7)
			if (store_remote) begin
				remote_temp_value_frac <= {code[1:0], 6'h00}; // see (R8)
				if (!frac_lock)
					remote_temp_value_int <= code_int; // see (R9)
			end
			if (ev_read && register_pointer == RD_REMOTE_FRAC)
				frac_lock <= 1'b1; // see (R9)
			else if (ev_read && register_pointer == RD_REMOTE_INT)
				frac_lock <= 1'b0;
		end
	end

	// ----------------------------------------
	// Flags and shutdown latches
	// ----------------------------------------
	logic shut_local, shut_remote;
	logic [7:0] flag_set;

	always_comb begin
		flag_set = RST_ZERO;
		flag_set[FLAG_LOCAL_HI] = store_local && local_hi; // see (R2)
		flag_set[FLAG_LOCAL_LO] = store_local && local_lo;
		flag_set[FLAG_REMOTE_HI] = store_remote && remote_hi;
		flag_set[FLAG_REMOTE_LO] = store_remote && remote_lo;
		flag_set[FLAG_OPEN] = ce && open_s2; // see (R4)
		flag_set[FLAG_LOCAL_SHUT] = store_local && local_over;
		flag_set[FLAG_REMOTE_SHUT] = store_remote && remote_over;
	end

	// Reading the flags clears them; a set in the same cycle wins
	wire flag_clear = ev_read && register_pointer == RD_FLAGS;
	wire [7:0] next_flags = (flag_clear ? RST_ZERO : limit_flags) | flag_set;

	always_ff @(posedge clock) begin
		if (rst) begin
			limit_flags <= RST_ZERO;
			shut_local <= 1'b0;
			shut_remote <= 1'b0;
		end else if (ce) begin
			limit_flags <= next_flags; // see (R2)
			if (store_local)
				shut_local <= local_over || (shut_local && !local_rel); // see (R5) (R17)
			if (store_remote)
				shut_remote <= remote_over || (shut_remote && !remote_rel); // see (R5) (R17)
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	wire shut_any = shut_local || shut_remote;
	wire alarm_any = |(limit_flags & ALARM_FLAGS) && !device_setup[SETUP_ALARM_MASK];

	always_ff @(posedge clock) begin
		if (rst) begin
			overtemp_shutdown_n_oe_n <= 1'b1;
			alarm_or_second_shutdown_n_oe_n <= 1'b1;
		end else if (ce) begin
			overtemp_shutdown_n_oe_n <= !shut_any; // see (R5)
			alarm_or_second_shutdown_n_oe_n <= device_setup[SETUP_PIN6_SHUT] ?
				!shut_any : !alarm_any; // see (R3) (R4)
		end
	end

	// Open drain: only ever pulls low
	assign overtemp_shutdown_n_out = 1'b0;
	assign alarm_or_second_shutdown_n_out = 1'b0;

endmodule // dtl_bank

// File: bench/dtl_bank_properties.sv
`timescale 1ns/100ps
module dtl_bank_properties (
	// Core domain
	input wire logic clock,
	input wire logic rst,
	input wire logic conv_start,
	input wire logic sample_valid,
	input wire logic diode_open,
	input wire logic overtemp_shutdown_n_oe_n,
	input wire logic alarm_or_second_shutdown_n_oe_n,
	// Link domain
	input wire logic link_clk,
	input wire logic link_byte_valid,
	input wire logic link_read_req,
	input wire logic link_read_valid,
	input wire logic link_busy
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_req;
		(link_byte_valid || link_read_req) && !link_busy;
	endsequence
	// Shutdown pin moves only after a store, some cycles after a sample
	sequence s_stored;
		$past(sample_valid, 2) || $past(sample_valid, 3) || $past(sample_valid, 4);
	endsequence
	reset_quiet_a: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> !conv_start && overtemp_shutdown_n_oe_n && alarm_or_second_shutdown_n_oe_n)
		else $error("outputs active after reset");
	conv_pulse_a: assert property (@(posedge clock) disable iff (rst)
		conv_start |=> !conv_start) else $error("start pulse too long");
	shut_pin_a: assert property (@(posedge clock) disable iff (rst)
		$changed(overtemp_shutdown_n_oe_n) |-> s_stored) else $error("shutdown pin moved alone");
	alarm_open_a: assert property (@(posedge clock) disable iff (rst)
		$rose(diode_open) |-> ##[1:80] !alarm_or_second_shutdown_n_oe_n)
		else $error("open diode gave no alarm");
	req_taken_a: assert property (@(posedge link_clk) disable iff (rst)
		s_req |=> link_busy) else $error("request not taken");
	busy_cause_a: assert property (@(posedge link_clk) disable iff (rst)
		$rose(link_busy) |-> $past(link_byte_valid) || $past(link_read_req))
		else $error("busy without request");
	busy_bound_a: assert property (@(posedge link_clk) disable iff (rst)
		$rose(link_busy) |-> ##[1:16] !link_busy) else $error("link stuck busy");
	read_end_a: assert property (@(posedge link_clk) disable iff (rst)
		link_read_valid |-> $fell(link_busy)) else $error("read answer off busy end");
endmodule // dtl_bank_properties
bind dtl_bank dtl_bank_properties dtl_bank_properties_inst (.clock, .rst, .conv_start,
	.sample_valid, .diode_open, .overtemp_shutdown_n_oe_n, .alarm_or_second_shutdown_n_oe_n,
	.link_clk, .link_byte_valid, .link_read_req, .link_read_valid, .link_busy);

// File: bench/dtl_conv_model.sv
`timescale 1ns/100ps
module dtl_conv_model (
	// Core side
	input wire logic clock,
	input wire logic conv_start,
	input wire logic conv_remote,
	output logic sample_valid,
	output logic signed [11:0] sample_temp,
	// Bench control
	input wire logic signed [11:0] local_q,
	input wire logic signed [11:0] remote_q,
	input wire logic [3:0] lag
);
	logic [3:0] cnt = 4'h0;
	logic busy = 1'b0;
	initial sample_valid = 1'b0;
	initial sample_temp = 12'h000;
	always @(posedge clock) begin
		sample_valid <= 1'b0;
		// Idle bus toggles, so a stale reading is never taken
		sample_temp <= ~sample_temp;
		if (conv_start) begin
			busy <= 1'b1;
			cnt <= lag;
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			sample_valid <= 1'b1;
			sample_temp <= conv_remote ? remote_q : local_q;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule // dtl_conv_model

// File: bench/dual_temp_result_limit_bank_tb_top.sv
`timescale 1ns/100ps
module dual_temp_result_limit_bank_tb_top;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
	logic clock = 0, rst = 1, link_clk = 0, link_frame = 0, link_byte_valid = 0;
	logic link_read_req = 0, diode_open = 0, link_read_valid, link_busy, conv_start, conv_remote;
	logic [7:0] link_byte = 8'h00, rd_val, d, a, link_read_data;
	logic signed [11:0] local_q = 12'sh064, remote_q = 12'sh064, sample_temp;
	logic [3:0] lag = 4'h1;
	logic sample_valid, overtemp_shutdown_n_out, overtemp_shutdown_n_oe_n;
	logic alarm_or_second_shutdown_n_out, alarm_or_second_shutdown_n_oe_n;
	wire overtemp_shutdown_n_in = overtemp_shutdown_n_oe_n | overtemp_shutdown_n_out;
	wire alarm_or_second_shutdown_n_in = alarm_or_second_shutdown_n_oe_n |
		alarm_or_second_shutdown_n_out;
	int n_checks = 0, n_mismatch = 0, seed = 32'h818a761a, starts = 0;
	logic [7:0] wa[13] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13, 8'h14,
		8'h19, 8'h20, 8'h21, 8'h22};
	logic [7:0] rv[13] = '{8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h55, 8'h55, 8'h0a, 8'h01};
	dtl_bank #(.TIMEOUT_LEN(400), .REVISION(8'h3c)) dtl_bank_inst (.clock, .rst, .ce(1'b1),
		.link_clk, .link_frame, .link_byte_valid, .link_byte, .link_read_req, .link_read_data,
		.link_read_valid, .link_busy, .conv_start, .conv_remote, .sample_valid, .sample_temp,
		.diode_open, .overtemp_shutdown_n_in, .overtemp_shutdown_n_out, .overtemp_shutdown_n_oe_n,
		.alarm_or_second_shutdown_n_in, .alarm_or_second_shutdown_n_out,
		.alarm_or_second_shutdown_n_oe_n);
	dtl_conv_model dtl_conv_model_inst (.clock, .conv_start, .conv_remote, .sample_valid,
		.sample_temp, .local_q, .remote_q, .lag);
	initial forever #4 clock = ~clock;
	initial #37 forever #62.5 link_clk = ~link_clk;
	always @(posedge clock) if (conv_start === 1'b1) starts++;
	// Result byte from quarter degrees, clamped to the range
	function automatic logic [7:0] enc(input int q, input bit ext, input bit fr);
		int t;
		t = (q >>> 2) + (ext ? 64 : 0);
		if (t < 0) return 8'h00;
		if (t > (ext ? 255 : 127)) return fr ? {ext, ext, 6'h00} : {ext, 7'h7f};
		return fr ? {q[1:0], 6'h00} : t[7:0];
	endfunction
	task automatic send(input logic rd, input logic [7:0] b);
		int i;
		@(posedge link_clk) #1;
		link_read_req = rd;
		link_byte_valid = !rd;
		link_byte = b;
		@(posedge link_clk) #1;
		link_read_req = 0;
		link_byte_valid = 0;
		link_byte = ~b;
		for (i = 0; i < 20 && link_busy !== 1'b0; i++) begin
			@(posedge link_clk) #1;
			if (link_read_valid === 1'b1) rd_val = link_read_data;
		end
		`CHK(link_busy, 1'b0)
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		@(posedge link_clk) #1 link_frame = 1;
		send(0, p);
		send(0, v);
		@(posedge link_clk) #1 link_frame = 0;
	endtask
	task automatic rd(input logic [7:0] p);
		@(posedge link_clk) #1 link_frame = 1;
		send(0, p);
		@(posedge link_clk) #1 link_frame = 0;
		rd_val = 8'hxx;
		send(1, 8'h00);
	endtask
	task automatic set_t(input int l, input int r);
		@(posedge clock) #1;
		local_q = 12'(l);
		remote_q = 12'(r);
		lag = 4'($random(seed));
		repeat (80) @(posedge clock);
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial #700000 begin
		n_mismatch++;
		results;
	end
	initial begin
		// Link side syncs reset, so hold it over several link edges
		repeat (70) @(posedge clock);
		#1 rst = 0;
		repeat (8) @(posedge link_clk);
		rd(8'h30);
		`CHK(rd_val, 8'h00)
		foreach (wa[i]) begin
			a = wa[i] < 8'h0f ? wa[i] - 8'h06 : wa[i];
			rd(a);
			`CHK(rd_val, rv[i])
			d = 8'($random(seed)) & ((a > 8'h11 && a < 8'h15) ? 8'hc0 : 8'hff);
			wr(wa[i], d);
			rd(a);
			`CHK(rd_val, d)
			wr(wa[i], rv[i]);
		end
		$display("register test done");
		for (int i = 0; i < 5; i++) begin
			if (i == 4) set_t(-20, 800);
			else set_t(({$random(seed)} % 130) * 4, {$random(seed)} % 600);
			rd(8'h00);
			`CHK(rd_val, enc(local_q, 0, 0))
			rd(8'h10);
			`CHK(rd_val, enc(remote_q, 0, 1))
			rd(8'h01);
			`CHK(rd_val, enc(remote_q, 0, 0))
		end
		wr(8'hff, 8'h00);
		rd(8'hff);
		`CHK(rd_val, 8'h3c)
		set_t(320, 120);
		rd(8'h10);
		set_t(320, 160);
		rd(8'h01);
		`CHK(rd_val, 8'h1e)
		set_t(320, 160);
		rd(8'h01);
		`CHK(rd_val, 8'h28)
		$display("value test done");
		wr(8'h09, 8'h04);
		set_t(100, -220);
		rd(8'h00);
		`CHK(rd_val, enc(100, 1, 0))
		rd(8'h10);
		rd(8'h01);
		`CHK(rd_val, enc(-220, 1, 0))
		wr(8'h09, 8'h00);
		rd(8'h02);
		set_t(360, 120);
		`CHK(overtemp_shutdown_n_oe_n, 1'b0)
		`CHK(alarm_or_second_shutdown_n_oe_n, 1'b0)
		rd(8'h02);
		`CHK(rd_val, 8'h41)
		set_t(320, 120);
		`CHK(overtemp_shutdown_n_oe_n, 1'b0)
		set_t(300, 120);
		`CHK(overtemp_shutdown_n_oe_n, 1'b1)
		rd(8'h02);
		set_t(300, 120);
		`CHK(alarm_or_second_shutdown_n_oe_n, 1'b1)
		@(posedge clock) #1 diode_open = 1;
		set_t(300, 120);
		`CHK(alarm_or_second_shutdown_n_oe_n, 1'b0)
		rd(8'h02);
		`CHK(rd_val[2], 1'b1)
		@(posedge clock) #1 diode_open = 0;
		$display("limit test done");
		wr(8'h09, 8'h40);
		starts = 0;
		set_t(300, 120);
		`CHK(starts, 0)
		wr(8'h0f, 8'($random(seed)));
		set_t(300, 120);
		`CHK(starts, 2)
		wr(8'h0a, 8'h05);
		wr(8'h0f, 8'h00);
		repeat (900) @(posedge clock);
		`CHK(starts, 34)
		$display("trigger test done");
		results;
	end
endmodule // dual_temp_result_limit_bank_tb_top
